// [core/urhd_map.vh]
// Purpose: constants for the root hub descriptor and low-speed cutoff registers
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: reserved bits are not stored
// Behaviour
// - The 12-bit cutoff is compared with the remaining bit count before a low-speed transfer.
// - Overcurrent status is reported only while no-overcurrent-protection is clear.
// - Overcurrent is reported per port with report mode set, else for all ports together.
// - The compound flag is read-only and shows the root hub is not a compound device.
// - With always-powered set port power follows controller on, else it may be switched.
// - With per-port power mode set masked ports are powered one by one, others all together; with it clear all together.
// - A read-only 8-bit field gives the number of downstream ports; the code reports PORT_COUNT, 3, with PORTS at 2.
// - The power-good delay and descriptor bits 12:0 reset only on hardware reset.
// - The remaining bit count is the frame down counter that the cutoff is compared with.
// - Port power mask bits 17 and 18 mask power control for ports 1 and 2 when set.
// - Port removable bits 1 and 2 hold the stored removable flags of ports 1 and 2, driven out on port_removable_flags.
`ifndef URHD_MAP_VH
`define URHD_MAP_VH
`define URHD_OFF_CUTOFF 8'h44
`define URHD_OFF_DESC_A 8'h48
`define URHD_OFF_DESC_B 8'h4c
`define URHD_RST_CUTOFF 12'h628
`define URHD_RST_PG_DELAY 8'hff
`define URHD_RST_NO_OCP 1'b0
`define URHD_RST_OC_MODE 1'b1
`define URHD_RST_ALWAYS_PWR 1'b0
`define URHD_RST_PP_MODE 1'b1
`define URHD_RST_PORT_COUNT 8'h03
`define URHD_RST_PWR_MASK 2'b11
`define URHD_RST_REMOVABLE 2'b00
`define URHD_B_FIXED_ONES 32'hfff80000
`define URHD_BIT_NO_OCP 12
`define URHD_BIT_OC_MODE 11
`define URHD_BIT_COMPOUND 10
`define URHD_BIT_ALWAYS_PWR 9
`define URHD_BIT_PP_MODE 8
`define URHD_BIT_MASK_P1 17
`define URHD_BIT_REM_P1 1
`define URHD_RESP_OKAY 2'b00
`define URHD_RESP_SLVERR 2'b10
`endif

// [core/urhd_cmp.v]
// Purpose: registered low-speed start check against end of frame
// Assumes: remaining count comes from the frame down counter, same clock
// Notes: one cycle of latency on the verdict
`timescale 1ns/1ps
module urhd_cmp #(
  parameter REM_W = 14,
  parameter CUT_W = 12
) (
  // clock and control
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // operands
  input wire [REM_W-1:0] remaining_bit_count,
  input wire [CUT_W-1:0] low_speed_cutoff,
  // verdict
  output reg ls_start_ok_reg
);
  wire ls_start_ok_next;
  // below the cutoff means no low-speed start
  assign ls_start_ok_next = (remaining_bit_count >= {{(REM_W-CUT_W){1'b0}}, low_speed_cutoff});
  always @(posedge aclk) begin
    if (!aresetn) begin
      ls_start_ok_reg <= 1'b0;
    end else if (ce) begin
      ls_start_ok_reg <= ls_start_ok_next;
    end
  end
endmodule

// [core/urhd_regs.v]
// Purpose: root hub descriptor and low-speed cutoff registers on AXI4-Lite
// Assumes: one write and one read outstanding at most
// Notes: aresetn is the hardware reset; ctrl_soft_reset spares the descriptors
`timescale 1ns/1ps
`include "urhd_map.vh"
module urhd_regs #(
  parameter ADDR_W = 8,
  parameter PORTS = 2,
  parameter [7:0] PORT_COUNT = `URHD_RST_PORT_COUNT
) (
  // clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire ctrl_soft_reset,
  // axi write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // frame timing
  input wire [13:0] remaining_bit_count,
  output wire ls_start_ok,
  // port power and overcurrent
  input wire controller_on,
  input wire global_power_req,
  input wire [PORTS-1:0] port_power_req,
  input wire [PORTS-1:0] overcurrent_in,
  output reg [PORTS-1:0] port_power_on,
  output reg [PORTS-1:0] port_overcurrent,
  output reg global_overcurrent,
  // descriptor fields to controller logic
  output reg [7:0] power_good_delay,
  output reg [PORTS-1:0] port_removable_flags
);
  // stored fields
  reg [11:0] low_speed_cutoff_reg;
  reg no_overcurrent_protection_reg;
  reg overcurrent_report_mode_reg;
  reg always_powered_reg;
  reg per_port_power_mode_reg;
  reg [1:0] port_power_mask_reg;
  reg [1:0] port_removable_reg;
  // write channel holding
  reg aw_full_reg;
  reg w_full_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  wire [31:0] strb_mask;
  wire [31:0] cut_word;
  wire [31:0] desc_a_word;
  wire [31:0] desc_b_word;
  wire [31:0] cut_new;
  wire [31:0] a_new;
  wire [31:0] b_new;
  wire do_write;
  wire wr_cut;
  wire wr_a;
  wire wr_b;
  wire wr_hit;
  reg [31:0] rd_word;
  reg rd_hit;

  assign strb_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                      {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  // reserved bits read zero; compound flag fixed at 0
  assign cut_word = {20'h00000, low_speed_cutoff_reg};
  assign desc_a_word = {power_good_delay, 11'h0, no_overcurrent_protection_reg,
                        overcurrent_report_mode_reg, 1'b0, always_powered_reg,
                        per_port_power_mode_reg, PORT_COUNT};
  assign desc_b_word = `URHD_B_FIXED_ONES | {13'h0, port_power_mask_reg, 14'h0,
                       port_removable_reg, 1'b0};
  // byte lanes merge into the current word
  assign cut_new = (cut_word & ~strb_mask) | (w_data_reg & strb_mask);
  assign a_new = (desc_a_word & ~strb_mask) | (w_data_reg & strb_mask);
  assign b_new = (desc_b_word & ~strb_mask) | (w_data_reg & strb_mask);
  assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
  // byte address compared as a whole word, sub-word bits ignored
  assign wr_cut = ({aw_addr_reg[7:2], 2'b00} == `URHD_OFF_CUTOFF);
  assign wr_a = ({aw_addr_reg[7:2], 2'b00} == `URHD_OFF_DESC_A);
  assign wr_b = ({aw_addr_reg[7:2], 2'b00} == `URHD_OFF_DESC_B);
  assign wr_hit = wr_cut || wr_a || wr_b;

  always @* begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `URHD_OFF_CUTOFF: rd_word = cut_word;
      `URHD_OFF_DESC_A: rd_word = desc_a_word;
      `URHD_OFF_DESC_B: rd_word = desc_b_word;
      default: rd_hit = 1'b0;
    endcase
  end

  // write path: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `URHD_RESP_OKAY;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (ce) begin
      if (!aw_full_reg && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
      end
      if (!w_full_reg && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `URHD_RESP_OKAY : `URHD_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
      end
    end
  end

  // field storage; only writable bits take data
  always @(posedge aclk) begin
    if (!aresetn) begin
      low_speed_cutoff_reg <= `URHD_RST_CUTOFF;
      power_good_delay <= `URHD_RST_PG_DELAY;
      no_overcurrent_protection_reg <= `URHD_RST_NO_OCP;
      overcurrent_report_mode_reg <= `URHD_RST_OC_MODE;
      always_powered_reg <= `URHD_RST_ALWAYS_PWR;
      per_port_power_mode_reg <= `URHD_RST_PP_MODE;
      port_power_mask_reg <= `URHD_RST_PWR_MASK;
      port_removable_reg <= `URHD_RST_REMOVABLE;
    end else if (ce) begin
      // soft reset touches the cutoff only, descriptors keep their values
      if (ctrl_soft_reset) begin
        low_speed_cutoff_reg <= `URHD_RST_CUTOFF;
      end else if (do_write && wr_cut) begin
        low_speed_cutoff_reg <= cut_new[11:0];
      end
      if (do_write && wr_a) begin
        power_good_delay <= a_new[31:24];
        no_overcurrent_protection_reg <= a_new[`URHD_BIT_NO_OCP];
        overcurrent_report_mode_reg <= a_new[`URHD_BIT_OC_MODE];
        always_powered_reg <= a_new[`URHD_BIT_ALWAYS_PWR];
        per_port_power_mode_reg <= a_new[`URHD_BIT_PP_MODE];
      end
      if (do_write && wr_b) begin
        port_power_mask_reg <= b_new[`URHD_BIT_MASK_P1+1:`URHD_BIT_MASK_P1];
        port_removable_reg <= b_new[`URHD_BIT_REM_P1+1:`URHD_BIT_REM_P1];
      end
    end
  end

  // read path: data registered with the accept
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `URHD_RESP_OKAY;
    end else if (ce) begin
      if (!s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `URHD_RESP_OKAY : `URHD_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // port power and overcurrent steering
  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      port_power_on <= {PORTS{1'b0}};
      port_overcurrent <= {PORTS{1'b0}};
      global_overcurrent <= 1'b0;
      port_removable_flags <= {PORTS{1'b0}};
    end else if (ce) begin
      for (i = 0; i < PORTS; i = i + 1) begin
        port_removable_flags[i] <= (i < 2) ? port_removable_reg[i] : 1'b0;
        if (always_powered_reg) begin
          port_power_on[i] <= controller_on;
        end else if (per_port_power_mode_reg && (i < 2) && port_power_mask_reg[i]) begin
          // masked port ignores the gang request
          port_power_on[i] <= port_power_req[i];
        end else begin
          port_power_on[i] <= global_power_req;
        end
        // per-port reporting only when protection exists
        port_overcurrent[i] <= !no_overcurrent_protection_reg &&
                               overcurrent_report_mode_reg && overcurrent_in[i];
      end
      global_overcurrent <= !no_overcurrent_protection_reg &&
                            !overcurrent_report_mode_reg && (|overcurrent_in);
    end
  end

  urhd_cmp #(
    .REM_W(14),
    .CUT_W(12)
  ) u_cmp (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .remaining_bit_count(remaining_bit_count),
    .low_speed_cutoff(low_speed_cutoff_reg),
    .ls_start_ok_reg(ls_start_ok)
  );
endmodule

// [sim/urhd_regs_chk.sv]
// Purpose: port checks for urhd_regs
// Assumes: ce high around bus traffic
// Notes: fields are internal, so checks bound outputs by inputs
`timescale 1ns/1ps
module urhd_regs_chk #(parameter PORTS = 2) (
  // clock
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // frame and ports
  input wire [13:0] remaining_bit_count,
  input wire ls_start_ok,
  input wire controller_on,
  input wire global_power_req,
  input wire [PORTS-1:0] port_power_req,
  input wire [PORTS-1:0] overcurrent_in,
  input wire [PORTS-1:0] port_power_on,
  input wire [PORTS-1:0] port_overcurrent,
  input wire global_overcurrent
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_cut_max: assert property (ce && &remaining_bit_count |=> ls_start_ok)
    else $error("verdict low at full frame");
  a_oc_quiet: assert property
    (ce && !(|overcurrent_in) |=> !global_overcurrent && !(|port_overcurrent))
    else $error("overcurrent without cause");
  a_oc_excl: assert property (!(global_overcurrent && |port_overcurrent))
    else $error("both report modes active");
  a_pwr_off: assert property
    (ce && !controller_on && !global_power_req && !(|port_power_req)
    |=> !(|port_power_on))
    else $error("power without request");
  a_pwr_src: assert property
    ($past(ce) && port_power_on[0]
    |-> $past(controller_on || port_power_req[0] || global_power_req))
    else $error("port power without source");
  a_wr_resp: assert property
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_rd_ans: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  cover property (s_axi_rvalid && !s_axi_rready);
  cover property (|port_overcurrent);
  cover property (global_overcurrent);
endmodule
bind urhd_regs urhd_regs_chk #(.PORTS(PORTS)) u_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .ce(ce),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata),
  .remaining_bit_count(remaining_bit_count),
  .ls_start_ok(ls_start_ok),
  .controller_on(controller_on),
  .global_power_req(global_power_req),
  .port_power_req(port_power_req),
  .overcurrent_in(overcurrent_in),
  .port_power_on(port_power_on),
  .port_overcurrent(port_overcurrent),
  .global_overcurrent(global_overcurrent)
);

// [sim/test_usb_root_hub_descriptor_regs.sv]
// Purpose: register and port tests for urhd_regs
// Assumes: bus timing as handed over, ce held high during bus traffic
// Notes: port outputs lag inputs by one edge
`timescale 1ns/1ps
`include "urhd_map.vh"
module test_usb_root_hub_descriptor_regs;
  reg aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, ctrl_soft_reset = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg [13:0] remaining_bit_count = 14'h0;
  reg controller_on = 1'b0, global_power_req = 1'b0;
  reg [1:0] port_power_req = 2'h0, overcurrent_in = 2'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ls_start_ok;
  wire [1:0] s_axi_bresp, s_axi_rresp, port_power_on, port_overcurrent, port_removable_flags;
  wire global_overcurrent;
  wire [31:0] s_axi_rdata;
  wire [7:0] power_good_delay;
  integer failures = 0, cmp_count = 0;
  initial forever #25 aclk = ~aclk;
  urhd_regs u_dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .ctrl_soft_reset(ctrl_soft_reset),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .remaining_bit_count(remaining_bit_count),
    .ls_start_ok(ls_start_ok),
    .controller_on(controller_on),
    .global_power_req(global_power_req),
    .port_power_req(port_power_req),
    .overcurrent_in(overcurrent_in),
    .port_power_on(port_power_on),
    .port_overcurrent(port_overcurrent),
    .global_overcurrent(global_overcurrent),
    .power_good_delay(power_good_delay),
    .port_removable_flags(port_removable_flags)
  );
  task check(input [31:0] s, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("CHECK FAILED %0t got %h want %h", $time, s, e);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge aclk);
  endtask
  // both channels offered together, each released once taken
  task wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    reg ad, wd;
    begin
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(ad && wd)) begin
        @(posedge aclk);
        ad = ad | s_axi_awready;
        wd = wd | s_axi_wready;
        s_axi_awvalid <= !ad;
        s_axi_wvalid <= !wd;
      end
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'b0;
      check(s_axi_bresp, er);
    end
  endtask
  // rready raised late so the held answer is seen for a cycle
  task rd(input [7:0] a, input [31:0] e, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      @(posedge aclk);
      while (!s_axi_arready) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, e);
      check(s_axi_rresp, er);
    end
  endtask
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    tick(5000);
    failures = failures + 1;
    complete_run;
  end
  initial begin
    tick(10);
    aresetn <= 1'b1;
    tick(2);
    rd(8'h44, 32'h00000628, 2'h0);
    rd(8'h48, 32'hff000903, 2'h0);
    rd(8'h4c, 32'hfffe0000, 2'h0);
    // reserved bits written as zero, read-only fields written as ones
    wr(8'h48, 32'hff001fff, 4'hf, 2'h0);
    rd(8'h48, 32'hff001b03, 2'h0);
    wr(8'h48, 32'h55000000, 4'h8, 2'h0);
    check(power_good_delay, 8'h55);
    wr(8'h50, 32'h0, 4'hf, 2'h2);
    rd(8'h50, 32'h0, 2'h2);
    wr(8'h44, 32'h00000123, 4'hf, 2'h0);
    rd(8'h44, 32'h00000123, 2'h0);
    remaining_bit_count <= 14'h123;
    tick(2);
    check(ls_start_ok, 1'b1);
    remaining_bit_count <= 14'h122;
    tick(2);
    check(ls_start_ok, 1'b0);
    remaining_bit_count <= 14'h3fff;
    tick(2);
    check(ls_start_ok, 1'b1);
    // verdict frozen while the enable is low
    ce <= 1'b0;
    remaining_bit_count <= 14'h0;
    tick(2);
    check(ls_start_ok, 1'b1);
    ce <= 1'b1;
    tick(2);
    check(ls_start_ok, 1'b0);
    // controller reset must spare the descriptors
    ctrl_soft_reset <= 1'b1;
    tick(1);
    ctrl_soft_reset <= 1'b0;
    rd(8'h44, 32'h00000628, 2'h0);
    rd(8'h48, 32'h55001b03, 2'h0);
    wr(8'h4c, 32'hfff80006, 4'hf, 2'h0);
    rd(8'h4c, 32'hfff80006, 2'h0);
    check(port_removable_flags, 2'b11);
    controller_on <= 1'b1;
    // settle time for new port power, one delay unit taken as one cycle
    tick(85);
    check(port_power_on, 2'b11);
    wr(8'h48, 32'h00000100, 4'h2, 2'h0);
    wr(8'h4c, 32'h00fa0000, 4'h4, 2'h0);
    port_power_req <= 2'b11;
    tick(2);
    check(port_power_on, 2'b01);
    port_power_req <= 2'b00;
    global_power_req <= 1'b1;
    tick(2);
    check(port_power_on, 2'b10);
    overcurrent_in <= 2'b10;
    tick(2);
    check({global_overcurrent, port_overcurrent}, 3'b100);
    // port outputs settle one edge after the field update
    wr(8'h48, 32'h00000900, 4'h2, 2'h0);
    tick(1);
    check({global_overcurrent, port_overcurrent}, 3'b010);
    wr(8'h48, 32'h00001900, 4'h2, 2'h0);
    tick(1);
    check({global_overcurrent, port_overcurrent}, 3'b000);
    // hardware reset restores the descriptors
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    tick(2);
    check(power_good_delay, 8'hff);
    rd(8'h48, 32'hff000903, 2'h0);
    rd(8'h4c, 32'hfffe0000, 2'h0);
    complete_run;
  end
endmodule
